// ===== core/lmd_pkg.sv
// Purpose: Shared constants and types for the LED matrix dimming controller.
// Assumes: Avalon-MM register access, 10 MHz core clock.
// Notes: Offsets are byte addresses; every register is one aligned word.
package lmd_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int CLK_MHZ = CLK_HZ / 1000000;
    localparam int PWM_FAST_HZ = 125000;
    localparam int PWM_SLOW_HZ = 62500;
    localparam logic [7:0] PWM_FAST_CYC = 8'(CLK_HZ / PWM_FAST_HZ);
    localparam logic [7:0] PWM_SLOW_CYC = 8'(CLK_HZ / PWM_SLOW_HZ);
    localparam int PHASE_NS = 125;
    localparam logic [7:0] PHASE_CYC = 8'((PHASE_NS * CLK_MHZ + 999) / 1000);
    localparam int BLANK_NS = 1000;
    localparam logic [7:0] BLANK_CYC = 8'((BLANK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] ON_SHIFT_CYC = 8'h01;
    localparam int SINKS = 18;
    localparam int LINES = 4;
    localparam int DOTS = SINKS * LINES;
    localparam int GROUPS = 3;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_MAXCUR = 12'h004;
    localparam logic [11:0] REG_COLOR = 12'h008;
    localparam logic [11:0] REG_GLOBAL = 12'h00c;
    localparam logic [11:0] REG_GROUP = 12'h010;
    localparam logic [11:0] REG_FAULT = 12'h014;
    localparam logic [11:0] REG_OPEN_CLR = 12'h018;
    localparam logic [11:0] REG_SHORT_CLR = 12'h01c;
    localparam logic [2:0] REGION_CORE = 3'h0;
    localparam logic [2:0] REGION_DOT = 3'h1;
    localparam logic [2:0] REGION_WIDE = 3'h2;
    localparam logic [2:0] REGION_FLAG = 3'h3;
    localparam int CTRL_CHIP_EN = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_LINES = 3;
    localparam int CTRL_FREQ = 5;
    localparam int CTRL_PHASE = 6;
    localparam int CTRL_SHIFT = 7;
    localparam int CTRL_SCALE = 8;
    localparam int CTRL_OPEN_CUT = 9;
    localparam int CTRL_SHORT_DGH = 10;
    localparam int DOT_GAIN_LSB = 8;
    localparam int DOT_GROUP_LSB = 16;
    localparam int DOT_ON_BIT = 18;
    localparam int COLOR_STRIDE = 8;
    localparam logic [2:0] MC_RST = 3'h3;
    localparam logic [6:0] CC_RST = 7'h40;
    localparam logic [7:0] DOT_GAIN_RST = 8'h80;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [15:0] CC_FULL = 16'h007f;
    localparam logic [31:0] DUTY_DIV = 32'h0000fe01;
    localparam logic [1:0] MODE_INSTANT = 2'h1;
    localparam logic [1:0] MODE_FRAME8 = 2'h2;
    localparam logic [1:0] MODE_FRAME16 = 2'h3;
    localparam logic [1:0] LINES_RST = 2'h3;
    localparam logic [7:0] CLEAR_CODE = 8'h0f;
    localparam logic [7:0] DETECT_MIN8 = 8'h19;
    localparam logic [15:0] DETECT_MIN16 = 16'h1900;
    localparam logic [2:0] QUAL_SUBPERIODS = 3'h4;
    typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} lmd_bus_e;
endpackage

// ===== core/lmd_top.sv
// Purpose: Dimming, scan timing, frame refresh and fault flags of an 18 x 4 LED matrix.
// Assumes: One 10 MHz clock; comparator and frame sync pins are asynchronous.
// Notes: Registers sit behind an Avalon-MM slave with one wait cycle per access.
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1 - Hold 3-bit global maximum current code.
// RULE2 - Framed modes: take code only while disabled.
// RULE3 - Scan one to four lines per count.
// RULE4 - Three 7-bit colour gains, reset 64.
// RULE5 - Sink n belongs to colour group n mod 3.
// RULE6 - Per-dot 8-bit dot gain, reset 128.
// RULE7 - Current is max times colour times dot.
// RULE8 - Per-dot duty 8 or 16 bits, dithered.
// RULE9 - Two-bit group selector, 00 means none.
// RULE10 - Effective duty is individual times group times global.
// RULE11 - PWM rate 125 or 62.5 kHz selectable.
// RULE12 - Optional three-phase stagger by sink mod 3.
// RULE13 - Optional one-clock sink delay after line on.
// RULE14 - Linear or exponential duty scale selectable.
// RULE15 - Per-dot on bit; cleared keeps dot dark.
// RULE16 - Mode one applies 8-bit writes at once.
// RULE17 - Modes two, three update frame on sync.
// RULE18 - Host pulses frame sync high each frame.
// RULE19 - 16-bit duty stored apart from 8-bit duty.
// RULE20 - Open needs duty threshold and four subperiods.
// RULE21 - Open sets global and dot flags; 0Fh clears.
// RULE22 - Open cutoff turns that sink off on line.
// RULE23 - Short needs duty threshold and four subperiods.
// RULE24 - Short sets global and dot flags; 0Fh clears.
// RULE25 - Short option disables line upside deghosting.
// RULE26 - Fault flags stay set until cleared.
// RULE27 - Qualification count restarts when condition absent.
module lmd_top (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    input wire logic [11:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic FRAME_SYNC,
    input wire logic [17:0] OPEN_CMP,
    input wire logic [17:0] SHORT_CMP,
    output logic [17:0] SINK_ON,
    output logic [143:0] SINK_CURRENT,
    output logic [2:0] MAX_CURRENT,
    output logic [3:0] LINE_ON,
    output logic [3:0] UPSIDE_DEGHOST_EN
);

    typedef struct packed {
        lmd_pkg::lmd_bus_e bus;
        logic wait_req;
        logic [31:0] rdata;
        logic chip_en;
        logic [1:0] mode;
        logic [1:0] lines_m1;
        logic freq_slow;
        logic phase_en;
        logic shift_en;
        logic scale_exp;
        logic open_cut;
        logic short_dgh_off;
        logic [2:0] max_current_code;
        logic [2:0] mc_applied;
        logic [2:0][6:0] color_gain_code;
        logic [7:0] glob;
        logic [2:0][7:0] grp_duty;
        logic [71:0][7:0] duty8;
        logic [71:0][15:0] duty16;
        logic [71:0][7:0] dot_gain_code;
        logic [71:0][1:0] dot_group_select;
        logic [71:0] dot_on;
        logic [71:0][7:0] disp8;
        logic [71:0][15:0] disp16;
        logic [71:0] open_flag;
        logic [71:0] short_flag;
        logic [71:0][2:0] open_cnt;
        logic [71:0][2:0] short_cnt;
        logic any_open_fault_flag;
        logic any_short_fault_flag;
        logic [1:0] line;
        logic [7:0] cnt;
        logic [7:0] sub;
        logic sync_q1;
        logic sync_q2;
        logic sync_d;
        logic [17:0] ocmp_q1;
        logic [17:0] ocmp_q2;
        logic [17:0] scmp_q1;
        logic [17:0] scmp_q2;
        logic [17:0] sink_on;
        logic [17:0][7:0] sink_cur;
        logic [3:0] line_on;
        logic [3:0] deghost_en;
    } lmd_state_s;

    logic [1:0] rst_sync_r;
    logic rst_n;
    lmd_state_s st_r;
    lmd_state_s st_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release.

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Register read mux.

    function automatic logic [31:0] rd_word(input lmd_state_s s, input logic [11:0] a);
        logic [6:0] dot;
        logic [31:0] v;
        dot = a[8:2];
        v = 32'h0;
        if (a[11:9] == lmd_pkg::REGION_CORE) begin
            case (a)
                lmd_pkg::REG_CTRL: begin
                    v[lmd_pkg::CTRL_CHIP_EN] = s.chip_en;
                    v[lmd_pkg::CTRL_MODE +: 2] = s.mode;
                    v[lmd_pkg::CTRL_LINES +: 2] = s.lines_m1;
                    v[lmd_pkg::CTRL_FREQ] = s.freq_slow;
                    v[lmd_pkg::CTRL_PHASE] = s.phase_en;
                    v[lmd_pkg::CTRL_SHIFT] = s.shift_en;
                    v[lmd_pkg::CTRL_SCALE] = s.scale_exp;
                    v[lmd_pkg::CTRL_OPEN_CUT] = s.open_cut;
                    v[lmd_pkg::CTRL_SHORT_DGH] = s.short_dgh_off;
                end
                lmd_pkg::REG_MAXCUR: v[2:0] = s.max_current_code;
                lmd_pkg::REG_COLOR: begin
                    for (int g = 0; g < lmd_pkg::GROUPS; g++) begin
                        v[g * lmd_pkg::COLOR_STRIDE +: 7] = s.color_gain_code[g];
                    end
                end
                lmd_pkg::REG_GLOBAL: v[7:0] = s.glob;
                lmd_pkg::REG_GROUP: v[23:0] = s.grp_duty;
                lmd_pkg::REG_FAULT: v[1:0] = {s.any_short_fault_flag, s.any_open_fault_flag};
                default: v = 32'h0;
            endcase
        end else if (32'(dot) < lmd_pkg::DOTS) begin
            case (a[11:9])
                lmd_pkg::REGION_DOT: begin
                    v[7:0] = s.duty8[dot];
                    v[lmd_pkg::DOT_GAIN_LSB +: 8] = s.dot_gain_code[dot];
                    v[lmd_pkg::DOT_GROUP_LSB +: 2] = s.dot_group_select[dot];
                    v[lmd_pkg::DOT_ON_BIT] = s.dot_on[dot];
                end
                lmd_pkg::REGION_WIDE: v[15:0] = s.duty16[dot];
                lmd_pkg::REGION_FLAG: v[1:0] = {s.short_flag[dot], s.open_flag[dot]};
                default: v = 32'h0;
            endcase
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [31:0] wmask;
        logic [31:0] wv;
        logic [6:0] wdot;
        logic [7:0] pc;
        logic [7:0] slot_last;
        logic slot_end;
        logic frame_edge;
        logic [7:0] subrev;
        int dot;
        logic [7:0] ind8;
        logic [15:0] ind16;
        logic [7:0] gd;
        logic [31:0] p8;
        logic [31:0] p16;
        logic [7:0] eff8;
        logic [15:0] eff16;
        logic [15:0] d16;
        logic [31:0] sq;
        logic [23:0] prod;
        logic [7:0] width;
        logic [7:0] start;
        logic [15:0] cur;
        logic det_ok;
        wmask = 32'h0;
        wv = 32'h0;
        wdot = 7'h0;
        pc = 8'h0;
        slot_last = 8'h0;
        slot_end = 1'b0;
        frame_edge = 1'b0;
        subrev = 8'h0;
        dot = 0;
        ind8 = 8'h0;
        ind16 = 16'h0;
        gd = 8'h0;
        p8 = 32'h0;
        p16 = 32'h0;
        eff8 = 8'h0;
        eff16 = 16'h0;
        d16 = 16'h0;
        sq = 32'h0;
        prod = 24'h0;
        width = 8'h0;
        start = 8'h0;
        cur = 16'h0;
        det_ok = 1'b0;
        st_nxt = st_r;

        // Pin synchronisers.
        st_nxt.sync_q1 = FRAME_SYNC;
        st_nxt.sync_q2 = st_r.sync_q1;
        st_nxt.sync_d = st_r.sync_q2;
        st_nxt.ocmp_q1 = OPEN_CMP;
        st_nxt.ocmp_q2 = st_r.ocmp_q1;
        st_nxt.scmp_q1 = SHORT_CMP;
        st_nxt.scmp_q2 = st_r.scmp_q1;
        frame_edge = st_r.sync_q2 && !st_r.sync_d;

        // Line slot timing.
        pc = st_r.freq_slow ? lmd_pkg::PWM_SLOW_CYC : lmd_pkg::PWM_FAST_CYC; // [RULE11]
        slot_last = 8'(lmd_pkg::BLANK_CYC + lmd_pkg::ON_SHIFT_CYC + pc - 8'h01);
        if (st_r.phase_en) begin
            slot_last = 8'(slot_last + 2 * lmd_pkg::PHASE_CYC);
        end
        slot_end = st_r.cnt == slot_last;
        for (int b = 0; b < 8; b++) begin
            subrev[b] = st_r.sub[7 - b];
        end
        if (!st_r.chip_en) begin
            st_nxt.cnt = 8'h0;
            st_nxt.line = 2'h0;
        end else if (slot_end) begin
            st_nxt.cnt = 8'h0;
            if (st_r.line >= st_r.lines_m1) begin // [RULE3]
                st_nxt.line = 2'h0;
                st_nxt.sub = 8'(st_r.sub + 8'h01);
            end else begin
                st_nxt.line = 2'(st_r.line + 2'h1);
            end
        end else begin
            st_nxt.cnt = 8'(st_r.cnt + 8'h01);
        end
        for (int l = 0; l < lmd_pkg::LINES; l++) begin
            st_nxt.line_on[l] = st_r.chip_en && (st_r.line == 2'(l)) && (st_r.cnt >= lmd_pkg::BLANK_CYC)
                && !slot_end;
            st_nxt.deghost_en[l] = 1'b1;
            if (st_r.short_dgh_off && (2'(l) <= st_r.lines_m1)) begin
                for (int s = 0; s < lmd_pkg::SINKS; s++) begin
                    if (st_r.short_flag[l * lmd_pkg::SINKS + s]) begin
                        st_nxt.deghost_en[l] = 1'b0; // [RULE25]
                    end
                end
            end
        end

        // Frame update of the displayed duty.
        if (frame_edge && (st_r.mode != lmd_pkg::MODE_INSTANT)) begin // [RULE17] [RULE18]
            st_nxt.disp8 = st_r.duty8;
            st_nxt.disp16 = st_r.duty16;
        end

        // Bus slave with one wait cycle.
        case (st_r.bus)
            lmd_pkg::BUS_IDLE: begin
                if (READ || WRITE) begin
                    st_nxt.rdata = rd_word(st_r, ADDRESS);
                    st_nxt.bus = lmd_pkg::BUS_ACK;
                    st_nxt.wait_req = 1'b0;
                end
            end
            lmd_pkg::BUS_ACK: begin
                st_nxt.bus = lmd_pkg::BUS_IDLE;
                st_nxt.wait_req = 1'b1;
                if (WRITE) begin
                    wmask = {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}}, {8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
                    wv = (rd_word(st_r, ADDRESS) & ~wmask) | (WRITEDATA & wmask);
                    wdot = ADDRESS[8:2];
                    if (ADDRESS[11:9] == lmd_pkg::REGION_CORE) begin
                        case (ADDRESS)
                            lmd_pkg::REG_CTRL: begin
                                st_nxt.chip_en = wv[lmd_pkg::CTRL_CHIP_EN];
                                st_nxt.mode = (wv[lmd_pkg::CTRL_MODE +: 2] == 2'h0) ? lmd_pkg::MODE_INSTANT
                                    : wv[lmd_pkg::CTRL_MODE +: 2];
                                st_nxt.lines_m1 = wv[lmd_pkg::CTRL_LINES +: 2];
                                st_nxt.freq_slow = wv[lmd_pkg::CTRL_FREQ];
                                st_nxt.phase_en = wv[lmd_pkg::CTRL_PHASE];
                                st_nxt.shift_en = wv[lmd_pkg::CTRL_SHIFT];
                                st_nxt.scale_exp = wv[lmd_pkg::CTRL_SCALE];
                                st_nxt.open_cut = wv[lmd_pkg::CTRL_OPEN_CUT];
                                st_nxt.short_dgh_off = wv[lmd_pkg::CTRL_SHORT_DGH];
                                if (!st_r.chip_en && wv[lmd_pkg::CTRL_CHIP_EN]) begin
                                    st_nxt.mc_applied = st_r.max_current_code; // [RULE2]
                                end
                            end
                            lmd_pkg::REG_MAXCUR: begin
                                if ((st_r.mode == lmd_pkg::MODE_INSTANT) || !st_r.chip_en) begin // [RULE2]
                                    st_nxt.max_current_code = wv[2:0]; // [RULE1]
                                end
                            end
                            lmd_pkg::REG_COLOR: begin
                                for (int g = 0; g < lmd_pkg::GROUPS; g++) begin
                                    st_nxt.color_gain_code[g] = wv[g * lmd_pkg::COLOR_STRIDE +: 7]; // [RULE4]
                                end
                            end
                            lmd_pkg::REG_GLOBAL: st_nxt.glob = wv[7:0];
                            lmd_pkg::REG_GROUP: st_nxt.grp_duty = wv[23:0];
                            lmd_pkg::REG_OPEN_CLR: begin
                                if (wv[7:0] == lmd_pkg::CLEAR_CODE) begin // [RULE21]
                                    st_nxt.open_flag = 72'h0;
                                    st_nxt.any_open_fault_flag = 1'b0;
                                end
                            end
                            lmd_pkg::REG_SHORT_CLR: begin
                                if (wv[7:0] == lmd_pkg::CLEAR_CODE) begin // [RULE24]
                                    st_nxt.short_flag = 72'h0;
                                    st_nxt.any_short_fault_flag = 1'b0;
                                end
                            end
                            default: st_nxt.glob = st_r.glob;
                        endcase
                    end else if (32'(wdot) < lmd_pkg::DOTS) begin
                        case (ADDRESS[11:9])
                            lmd_pkg::REGION_DOT: begin
                                st_nxt.duty8[wdot] = wv[7:0]; // [RULE16]
                                st_nxt.dot_gain_code[wdot] = wv[lmd_pkg::DOT_GAIN_LSB +: 8]; // [RULE6]
                                st_nxt.dot_group_select[wdot] = wv[lmd_pkg::DOT_GROUP_LSB +: 2];
                                st_nxt.dot_on[wdot] = wv[lmd_pkg::DOT_ON_BIT];
                            end
                            lmd_pkg::REGION_WIDE: st_nxt.duty16[wdot] = wv[15:0]; // [RULE19]
                            default: st_nxt.glob = st_r.glob;
                        endcase
                    end
                end
            end
            default: st_nxt.bus = lmd_pkg::BUS_IDLE;
        endcase
        if (st_r.mode == lmd_pkg::MODE_INSTANT) begin
            st_nxt.mc_applied = st_nxt.max_current_code; // [RULE2]
        end

        // Per-sink duty, pulse placement, current and fault qualification.
        for (int s = 0; s < lmd_pkg::SINKS; s++) begin
            dot = 32'(st_r.line) * lmd_pkg::SINKS + s;
            ind8 = (st_r.mode == lmd_pkg::MODE_INSTANT) ? st_r.duty8[dot] : st_r.disp8[dot]; // [RULE16]
            ind16 = st_r.disp16[dot]; // [RULE8]
            gd = (st_r.dot_group_select[dot] == 2'h0) ? lmd_pkg::DUTY_FULL
                : st_r.grp_duty[st_r.dot_group_select[dot] - 2'h1]; // [RULE9]
            p8 = 32'(ind8) * 32'(gd) * 32'(st_r.glob); // [RULE10]
            p16 = 32'(ind16) * 32'(gd) / 32'(lmd_pkg::DUTY_FULL) * 32'(st_r.glob);
            eff8 = 8'(p8 / lmd_pkg::DUTY_DIV);
            eff16 = 16'(p16 / 32'(lmd_pkg::DUTY_FULL));
            d16 = (st_r.mode == lmd_pkg::MODE_FRAME16) ? eff16 : {eff8, 8'h00};
            if (st_r.scale_exp) begin
                sq = 32'(d16) * 32'(d16);
                d16 = sq[31:16]; // [RULE14]
            end
            prod = 24'(d16) * 24'(pc);
            width = prod[23:16];
            if ((st_r.mode == lmd_pkg::MODE_FRAME16) && (prod[15:8] > subrev)) begin
                width = 8'(width + 8'h01); // [RULE8]
            end
            start = lmd_pkg::BLANK_CYC;
            if (st_r.shift_en) begin
                start = 8'(start + lmd_pkg::ON_SHIFT_CYC); // [RULE13]
            end
            if (st_r.phase_en) begin
                start = 8'(start + 8'(s % lmd_pkg::GROUPS) * lmd_pkg::PHASE_CYC); // [RULE12]
            end
            st_nxt.sink_on[s] = st_r.chip_en && st_r.dot_on[dot] // [RULE15]
                && !(st_r.open_cut && st_r.open_flag[dot]) // [RULE22]
                && (st_r.cnt >= start) && (16'(st_r.cnt) < 16'(start) + 16'(width)) && !slot_end;
            cur = 16'(st_r.color_gain_code[s % lmd_pkg::GROUPS]) * 16'(st_r.dot_gain_code[dot]); // [RULE5]
            st_nxt.sink_cur[s] = 8'(cur / lmd_pkg::CC_FULL); // [RULE7]
            det_ok = (st_r.mode == lmd_pkg::MODE_FRAME16) ? (eff16 >= lmd_pkg::DETECT_MIN16)
                : (eff8 >= lmd_pkg::DETECT_MIN8);
            if (st_r.chip_en && slot_end) begin
                if (det_ok && st_r.ocmp_q2[s]) begin // [RULE20]
                    st_nxt.open_cnt[dot] = 3'(st_r.open_cnt[dot] + 3'h1);
                    if (st_nxt.open_cnt[dot] >= lmd_pkg::QUAL_SUBPERIODS) begin
                        st_nxt.open_cnt[dot] = lmd_pkg::QUAL_SUBPERIODS;
                        st_nxt.open_flag[dot] = 1'b1; // [RULE21] [RULE26]
                        st_nxt.any_open_fault_flag = 1'b1;
                    end
                end else begin
                    st_nxt.open_cnt[dot] = 3'h0; // [RULE27]
                end
                if (det_ok && st_r.scmp_q2[s]) begin // [RULE23]
                    st_nxt.short_cnt[dot] = 3'(st_r.short_cnt[dot] + 3'h1);
                    if (st_nxt.short_cnt[dot] >= lmd_pkg::QUAL_SUBPERIODS) begin
                        st_nxt.short_cnt[dot] = lmd_pkg::QUAL_SUBPERIODS;
                        st_nxt.short_flag[dot] = 1'b1; // [RULE24] [RULE26]
                        st_nxt.any_short_fault_flag = 1'b1;
                    end
                end else begin
                    st_nxt.short_cnt[dot] = 3'h0; // [RULE27]
                end
            end
        end

        if (!CLK_EN) begin
            st_nxt = st_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.bus <= lmd_pkg::BUS_IDLE;
            st_r.wait_req <= 1'b1;
            st_r.mode <= lmd_pkg::MODE_INSTANT;
            st_r.lines_m1 <= lmd_pkg::LINES_RST;
            st_r.max_current_code <= lmd_pkg::MC_RST;
            st_r.mc_applied <= lmd_pkg::MC_RST;
            st_r.color_gain_code <= {lmd_pkg::GROUPS{lmd_pkg::CC_RST}};
            st_r.glob <= lmd_pkg::DUTY_FULL;
            st_r.grp_duty <= {lmd_pkg::GROUPS{lmd_pkg::DUTY_FULL}};
            st_r.dot_gain_code <= {lmd_pkg::DOTS{lmd_pkg::DOT_GAIN_RST}};
            st_r.deghost_en <= 4'hf;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign READDATA = st_r.rdata;
    assign WAITREQUEST = st_r.wait_req;
    assign SINK_ON = st_r.sink_on;
    assign SINK_CURRENT = st_r.sink_cur;
    assign MAX_CURRENT = st_r.mc_applied;
    assign LINE_ON = st_r.line_on;
    assign UPSIDE_DEGHOST_EN = st_r.deghost_en;

endmodule

// ===== verification/lmd_top_monitor.sv
// Purpose: Port checker for lmd_top.
// Assumes: CLOCK is the only clock.
// Notes: Attached by the bind at the foot.
`timescale 1ns/1ps
module lmd_top_monitor (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] READDATA,
    input wire logic WAITREQUEST,
    input wire logic [17:0] SINK_ON,
    input wire logic [2:0] MAX_CURRENT,
    input wire logic [3:0] LINE_ON
);
    logic [7:0] on_cnt_r;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) on_cnt_r <= 8'h00;
        else on_cnt_r <= (|LINE_ON) ? on_cnt_r + 8'h01 : 8'h00;
    end
    a_wait_one_cycle: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST) else $error("late");
    a_wait_short: assert property (!WAITREQUEST |=> WAITREQUEST) else $error("long answer");
    a_read_hold: assert property (WAITREQUEST && !READ && !WRITE |=> $stable(READDATA)) else $error("rdata");
    a_line_onehot: assert property ($onehot0(LINE_ON)) else $error("lines");
    a_sink_in_line: assert property (|SINK_ON |-> |LINE_ON) else $error("sink off line");
    a_slot_length: assert property ($fell(|LINE_ON) |-> on_cnt_r inside {[8'h50:8'h56], [8'ha0:8'ha6]})
        else $error("slot");
    a_blank_gap: assert property ($fell(|LINE_ON) |-> !(|LINE_ON) [*8]) else $error("blank");
    a_maxcur_cause: assert property ($changed(MAX_CURRENT) |->
        $past(WRITE) || $past(WRITE, 2) || $past(WRITE, 3)) else $error("max current");
    cover property (!WAITREQUEST && READ);
    cover property ($changed(MAX_CURRENT));
    cover property (|SINK_ON);
endmodule
bind lmd_top lmd_top_monitor mon_u (.*);

// ===== verification/lmd_sync_host.sv
// Purpose: Host side frame sync source.
// Assumes: go is a one-cycle request.
// Notes: Pulse lasts five clocks.
`timescale 1ns/1ps
module lmd_sync_host (
    input wire logic clk,
    input wire logic go,
    output logic frame_sync = 1'b0
);
    logic [2:0] left_r = 3'h0;
    always @(posedge clk) begin
        left_r <= go ? 3'h4 : left_r - 3'(left_r != 3'h0);
        frame_sync <= go || left_r != 3'h0;
    end
endmodule

// ===== verification/lmd_top_bench.sv
// Purpose: Self-checking bench for lmd_top.
// Assumes: Expected values come from integer models.
// Notes: One idle cycle between bus accesses.
`timescale 1ns/1ps
module lmd_top_bench;
    logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, wait_q, go = 1'b0, fsync;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [17:0] open_cmp = 18'h0, short_cmp = 18'h0, sink_on, lit;
    logic [143:0] cur;
    logic [2:0] maxc;
    logic [3:0] line_on, dgh;
    int n_fail = 0, check_count = 0, cyc = 0, col[3], gain[18], v, k;
    always #50 clk = ~clk;
    lmd_top dut_u (.CLOCK(clk), .ARST_N(arst_n), .CLK_EN(1'b1), .ADDRESS(addr), .READ(rd), .WRITE(wr),
        .WRITEDATA(wdata), .BYTEENABLE(4'hf), .READDATA(rdata), .WAITREQUEST(wait_q), .FRAME_SYNC(fsync),
        .OPEN_CMP(open_cmp), .SHORT_CMP(short_cmp), .SINK_ON(sink_on), .SINK_CURRENT(cur),
        .MAX_CURRENT(maxc), .LINE_ON(line_on), .UPSIDE_DEGHOST_EN(dgh));
    lmd_sync_host host_u (.clk(clk), .go(go), .frame_sync(fsync));
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clk); while (wait_q !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rc(input string what, input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask
    task automatic obs;
        lit = 18'h0;
        repeat (400) @(negedge clk) lit |= sink_on;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        v = $urandom(16);
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rc("ctrl", lmd_pkg::REG_CTRL, 32'h1a);
        rc("color", lmd_pkg::REG_COLOR, 32'h404040);
        rc("dot", 12'h200, 32'h8000);
        rc("unmapped", 12'h020, 32'h0);
        acc(1'b1, lmd_pkg::REG_CTRL, 32'h1c);
        acc(1'b1, lmd_pkg::REG_MAXCUR, 32'h5);
        repeat (4) @(negedge clk);
        chk("maxc held", 32'h3, {29'h0, maxc});
        acc(1'b1, lmd_pkg::REG_CTRL, 32'h61d);
        acc(1'b1, lmd_pkg::REG_MAXCUR, 32'h6);
        repeat (4) @(negedge clk);
        chk("maxc applied", 32'h5, {29'h0, maxc});
        rc("maxc refused", lmd_pkg::REG_MAXCUR, 32'h5);
        for (k = 0; k < 3; k++) col[k] = $urandom_range(127);
        for (k = 0; k < 18; k++) gain[k] = $urandom_range(255);
        acc(1'b1, lmd_pkg::REG_COLOR, {9'h0, 7'(col[2]), 1'b0, 7'(col[1]), 1'b0, 7'(col[0])});
        acc(1'b1, lmd_pkg::REG_GROUP, 32'h00ff00);
        for (k = 0; k < 72; k++) acc(1'b1, 12'h200 + 12'(4 * k),
            {13'h0, 1'(k % 18 != 17), 2'(k % 18 < 4 ? k % 18 : 0), 8'(gain[k % 18]), 8'hff});
        obs();
        chk("held frame", 32'h0, {14'h0, lit});
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (10) @(posedge clk);
        obs();
        q = 32'h0;
        for (k = 0; k < 17; k++) q[k] = k > 3 || k == 0 || k == 2;
        chk("lit", q, {14'h0, lit});
        for (k = 0; k < 18; k++) chk("current", 32'(col[k % 3] * gain[k] / 127), {24'h0, cur[8*k+:8]});
        for (k = 0; k < 2; k++) begin
            {open_cmp, short_cmp} <= k == 0 ? {18'h10, 18'h0} : {18'h0, 18'h10};
            repeat (3000) @(posedge clk);
            rc("fault", lmd_pkg::REG_FAULT, 32'(k + 1));
            rc("dot flag", 12'h610, 32'(k + 1));
            chk("deghost", k ? 32'h0 : 32'hf, {28'h0, dgh});
            obs();
            chk("cutoff", k ? 32'h1fff5 : 32'h1ffe5, {14'h0, lit});
            {open_cmp, short_cmp} <= 36'h0;
            repeat (800) @(posedge clk);
            rc("sticky", lmd_pkg::REG_FAULT, 32'(k + 1));
            acc(1'b1, lmd_pkg::REG_OPEN_CLR + 12'(4 * k), 32'h0f);
            rc("cleared", lmd_pkg::REG_FAULT, 32'h0);
        end
        acc(1'b1, lmd_pkg::REG_CTRL, 32'h1b);
        v = $urandom_range(7);
        acc(1'b1, lmd_pkg::REG_MAXCUR, 32'(v));
        repeat (4) @(negedge clk);
        chk("maxc mode1", 32'(v), {29'h0, maxc});
        close_out();
    end
endmodule
